// ==== inc/btr_pkg.sv ====
// Constants and types for the battery thermistor limit register bank
package btr_pkg;
  localparam logic [7:0] cold_limit_offset = 8'h62;
  localparam logic [7:0] cool_limit_offset = 8'h63;
  localparam logic [7:0] warm_limit_offset = 8'h64;
  localparam logic [7:0] hot_limit_offset  = 8'h65;
  localparam logic [7:0] part_id_offset    = 8'h6F;
  localparam logic [7:0] cold_limit_reset  = 8'h7C;
  localparam logic [7:0] cool_limit_reset  = 8'h6D;
  localparam logic [7:0] warm_limit_reset  = 8'h38;
  localparam logic [7:0] hot_limit_reset   = 8'h27;
  localparam logic [7:0] unmapped_read     = 8'h00;
  localparam logic [3:0] bits_per_byte     = 4'h8;

  typedef enum logic [3:0] {
    btr_idle     = 4'b0000,
    btr_addr     = 4'b0001,
    btr_addr_ack = 4'b0010,
    btr_ptr      = 4'b0011,
    btr_ptr_ack  = 4'b0100,
    btr_wdata    = 4'b0101,
    btr_wdat_ack = 4'b0110,
    btr_rdata    = 4'b0111,
    btr_rack     = 4'b1000
  } btr_state_e;

  typedef enum logic [2:0] {
    btr_zone_normal = 3'b000,
    btr_zone_cool   = 3'b001,
    btr_zone_cold   = 3'b010,
    btr_zone_warm   = 3'b011,
    btr_zone_hot    = 3'b100
  } btr_zone_e;
endpackage

// ==== rtl/btr_regs.sv ====
// Thermistor zone limit registers behind a two-wire serial target
// What this block does
// - Cold limit register 0x62, reset 0x7C
// - Cool limit register 0x63, reset 0x6D
// - Warm limit register 0x64, reset 0x38
// - Hot limit register 0x65, reset 0x27
// - Read-only part code at 0x6F
// - Button press raises host interrupt
`timescale 1ns/1ps
module btr_regs #(
  parameter logic [6:0] target_addr = 7'h35,
  // Arbitrary value, not tied to any real part
  parameter logic [7:0] part_code   = 8'h5A
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output wire logic       sda_out,
  output logic            sda_oe_out,
  input  wire logic       push_button_n_in,
  output logic            host_int_out,
  input  wire logic [7:0] thermistor_sense_in,
  input  wire logic       thermistor_sense_valid_in,
  output btr_pkg::btr_zone_e zone_out
);
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] btn_sync;
  btr_pkg::btr_state_e state;
  btr_pkg::btr_state_e next_state;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       rw;
  logic       next_rw;
  logic       next_sda_oe;
  logic [7:0] limit [4];
  logic [7:0] next_limit [4];
  logic       next_host_int;
  btr_pkg::btr_zone_e next_zone;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic wr_en;
  logic load_rd;
  logic [7:0] load_ptr;

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] lim [4]);
    unique case (a)
      btr_pkg::cold_limit_offset: read_reg = lim[0];
      btr_pkg::cool_limit_offset: read_reg = lim[1];
      btr_pkg::warm_limit_offset: read_reg = lim[2];
      btr_pkg::hot_limit_offset:  read_reg = lim[3];
      btr_pkg::part_id_offset:    read_reg = part_code;
      default:                    read_reg = btr_pkg::unmapped_read;
    endcase
  endfunction

  // Stage 0 feeds only stage 1; edges come from stages 1 and 2
  assign scl_rise   = scl_sync[1] & ~scl_sync[2];
  assign scl_fall   = ~scl_sync[1] & scl_sync[2];
  assign start_cond = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  assign stop_cond  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
  // Open-drain line: only ever pulled low
  assign sda_out    = 1'b0;

  always_comb begin
    next_state   = state;
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    next_ptr     = ptr;
    next_rw      = rw;
    next_sda_oe  = sda_oe_out;
    next_limit   = limit;
    wr_en        = 1'b0;
    load_rd      = 1'b0;
    load_ptr     = ptr;
    if (stop_cond) begin
      next_state  = btr_pkg::btr_idle;
      next_sda_oe = 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the pointer for a combined read
      next_state   = btr_pkg::btr_addr;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        btr_pkg::btr_addr, btr_pkg::btr_ptr, btr_pkg::btr_wdata: begin
          next_shift   = {shift[6:0], sda_sync[1]};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        btr_pkg::btr_rdata: next_bit_cnt = bit_cnt + 4'h1;
        btr_pkg::btr_rack: begin
          if (sda_sync[1]) begin
            next_state = btr_pkg::btr_idle;
          end else begin
            load_rd      = 1'b1;
            load_ptr     = ptr + 8'h01;
            next_ptr     = load_ptr;
            next_shift   = read_reg(load_ptr, limit);
            next_bit_cnt = 4'h0;
            next_state   = btr_pkg::btr_rdata;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state)
        btr_pkg::btr_addr: begin
          if (bit_cnt == btr_pkg::bits_per_byte) begin
            if (shift[7:1] == target_addr) begin
              next_rw     = shift[0];
              next_sda_oe = 1'b1;
              next_state  = btr_pkg::btr_addr_ack;
            end else begin
              next_state = btr_pkg::btr_idle;
            end
          end
        end
        btr_pkg::btr_addr_ack: begin
          next_bit_cnt = 4'h0;
          if (rw) begin
            load_rd     = 1'b1;
            next_shift  = read_reg(ptr, limit);
            next_sda_oe = ~next_shift[7];
            next_state  = btr_pkg::btr_rdata;
          end else begin
            next_sda_oe = 1'b0;
            next_state  = btr_pkg::btr_ptr;
          end
        end
        btr_pkg::btr_ptr: begin
          if (bit_cnt == btr_pkg::bits_per_byte) begin
            next_ptr    = shift;
            next_sda_oe = 1'b1;
            next_state  = btr_pkg::btr_ptr_ack;
          end
        end
        btr_pkg::btr_wdata: begin
          if (bit_cnt == btr_pkg::bits_per_byte) begin
            // limit writes; part code ignores writes
            wr_en = 1'b1;
            for (int i = 0; i < 4; i++) begin
              if (ptr == btr_pkg::cold_limit_offset + 8'(i)) begin
                next_limit[i] = shift;
              end
            end
            next_ptr    = ptr + 8'h01;
            next_sda_oe = 1'b1;
            next_state  = btr_pkg::btr_wdat_ack;
          end
        end
        btr_pkg::btr_ptr_ack, btr_pkg::btr_wdat_ack: begin
          next_sda_oe  = 1'b0;
          next_bit_cnt = 4'h0;
          next_state   = btr_pkg::btr_wdata;
        end
        btr_pkg::btr_rdata: begin
          if (bit_cnt == btr_pkg::bits_per_byte) begin
            next_sda_oe = 1'b0;
            next_state  = btr_pkg::btr_rack;
          end else begin
            next_sda_oe = ~shift[3'(4'h7 - bit_cnt)];
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    next_host_int = btn_sync[2] & ~btn_sync[1];
    next_zone = zone_out;
    if (thermistor_sense_valid_in) begin
      if (thermistor_sense_in >= limit[0]) begin
        next_zone = btr_pkg::btr_zone_cold;
      end else if (thermistor_sense_in >= limit[1]) begin
        next_zone = btr_pkg::btr_zone_cool;
      end else if (thermistor_sense_in <= limit[3]) begin
        next_zone = btr_pkg::btr_zone_hot;
      end else if (thermistor_sense_in <= limit[2]) begin
        next_zone = btr_pkg::btr_zone_warm;
      end else begin
        next_zone = btr_pkg::btr_zone_normal;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sync     <= 3'h7;
      sda_sync     <= 3'h7;
      btn_sync     <= 3'h7;
      state        <= btr_pkg::btr_idle;
      shift        <= 8'h00;
      bit_cnt      <= 4'h0;
      ptr          <= 8'h00;
      rw           <= 1'b0;
      sda_oe_out   <= 1'b0;
      limit[0]     <= btr_pkg::cold_limit_reset;
      limit[1]     <= btr_pkg::cool_limit_reset;
      limit[2]     <= btr_pkg::warm_limit_reset;
      limit[3]     <= btr_pkg::hot_limit_reset;
      host_int_out <= 1'b0;
      zone_out     <= btr_pkg::btr_zone_normal;
    end else begin
      scl_sync     <= {scl_sync[1:0], scl_in};
      sda_sync     <= {sda_sync[1:0], sda_in};
      btn_sync     <= {btn_sync[1:0], push_button_n_in};
      state        <= next_state;
      shift        <= next_shift;
      bit_cnt      <= next_bit_cnt;
      ptr          <= next_ptr;
      rw           <= next_rw;
      sda_oe_out   <= next_sda_oe;
      limit        <= next_limit;
      host_int_out <= next_host_int;
      zone_out     <= next_zone;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  chk_cold_after_reset: assert property ($fell(rst_in) |->
    limit[0] == btr_pkg::cold_limit_reset)
    else $error("cold limit not at reset value");
  chk_cold_write_only: assert property (!$stable(limit[0]) |->
    $past(wr_en) && $past(ptr) == btr_pkg::cold_limit_offset)
    else $error("cold limit changed without write");
  chk_cool_write_only: assert property (!$stable(limit[1]) |->
    $past(wr_en) && $past(ptr) == btr_pkg::cool_limit_offset)
    else $error("cool limit changed without write");
  chk_warm_write_data: assert property (wr_en && ptr == btr_pkg::warm_limit_offset
    |=> limit[2] == $past(shift))
    else $error("warm limit did not take written byte");
  chk_hot_write_only: assert property (!$stable(limit[3]) |->
    $past(wr_en) && $past(ptr) == btr_pkg::hot_limit_offset)
    else $error("hot limit changed without write");
  chk_part_code_read: assert property (load_rd && load_ptr == btr_pkg::part_id_offset
    |=> shift == part_code)
    else $error("part code read wrong");
  chk_press_raises_irq: assert property ($fell(btn_sync[1]) |=>
    host_int_out ##1 !host_int_out)
    else $error("button press did not pulse interrupt");
  chk_zone_hot_class: assert property (thermistor_sense_valid_in
    && thermistor_sense_in <= limit[3] && thermistor_sense_in < limit[1]
    && thermistor_sense_in < limit[0] |=> zone_out == btr_pkg::btr_zone_hot)
    else $error("hot reading not classed hot");
  chk_zone_cold_class: assert property (thermistor_sense_valid_in
    && thermistor_sense_in >= limit[0] |=> zone_out == btr_pkg::btr_zone_cold)
    else $error("cold reading not classed cold");

  cov_limit_write: cover property (wr_en);
  cov_read_byte: cover property (state == btr_pkg::btr_rack && scl_rise && !sda_sync[1]);
  cov_button_irq: cover property (host_int_out);
  cov_zone_warm: cover property (zone_out == btr_pkg::btr_zone_warm);
endmodule // btr_regs

// ==== testbench/btr_host.sv ====
// Host model that drives the two-wire register bus
`timescale 1ns/1ps
module btr_host (
  input  wire logic core_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // Data moves mid-low so the target never sees it change with the clock
  task automatic bit_io(input logic b, output logic r);
    gap(4);
    sda_oe_out <= ~b;
    gap(4);
    scl_out <= 1'b1;
    gap(8);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic start;
    gap(4);
    sda_oe_out <= 1'b0;
    gap(4);
    scl_out <= 1'b1;
    gap(8);
    sda_oe_out <= 1'b1;
    gap(8);
    scl_out <= 1'b0;
  endtask
  task automatic stop;
    gap(4);
    sda_oe_out <= 1'b1;
    gap(4);
    scl_out <= 1'b1;
    gap(8);
    sda_oe_out <= 1'b0;
    gap(8);
  endtask
  task automatic byte_tx(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    a = ~r;
  endtask
  task automatic byte_rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
    logic k1, k2, k3;
    start;
    byte_tx({dev, 1'b0}, k1);
    byte_tx(a, k2);
    byte_tx(d, k3);
    stop;
    ok = k1 & k2 & k3;
  endtask
  // Repeated start keeps the pointer set by the first phase
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
    logic k;
    start;
    byte_tx({dev, 1'b0}, k);
    byte_tx(a, k);
    start;
    byte_tx({dev, 1'b1}, k);
    byte_rx(1'b1, d);
    stop;
  endtask
endmodule // btr_host

// ==== testbench/testbench.sv ====
// Self-checking bench for the thermistor limit register bank
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] dev_addr = 7'h35;
  // Arbitrary value, not tied to any real part
  localparam logic [7:0] id_code  = 8'hA5;
  logic               core_clk_in = 1'b0;
  logic               rst_in;
  logic               scl;
  logic               host_oe;
  logic               dut_oe;
  wire logic          sda;
  logic               button_n;
  logic               host_int;
  logic [7:0]         sense;
  logic               sense_valid;
  btr_pkg::btr_zone_e zone;
  logic [7:0]         d;
  logic               ok;
  int                 n_errors = 0;
  int                 n_compared = 0;
  int                 pulses;
  logic [7:0] offs[4] = '{8'h62, 8'h63, 8'h64, 8'h65};
  logic [7:0] rsts[4] = '{8'h7C, 8'h6D, 8'h38, 8'h27};
  logic [7:0] lims[4] = '{8'hC0, 8'hA0, 8'h40, 8'h20};
  logic [7:0] svals[6] = '{8'hC0, 8'hBF, 8'hA0, 8'h41, 8'h40, 8'h20};
  btr_pkg::btr_zone_e zexp[6] = '{btr_pkg::btr_zone_cold, btr_pkg::btr_zone_cool,
    btr_pkg::btr_zone_cool, btr_pkg::btr_zone_normal, btr_pkg::btr_zone_warm,
    btr_pkg::btr_zone_hot};
  // Open drain with pull-up: any party enabled pulls the line low
  assign sda = ~(host_oe | dut_oe);
  always #5 core_clk_in = ~core_clk_in;
  btr_regs #(.target_addr(dev_addr), .part_code(id_code)) dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(dut_oe), .push_button_n_in(button_n),
    .host_int_out(host_int), .thermistor_sense_in(sense),
    .thermistor_sense_valid_in(sense_valid), .zone_out(zone));
  btr_host host (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    wrap_up;
  end
  initial begin
    rst_in = 1'b1;
    button_n = 1'b1;
    sense = 8'h00;
    sense_valid = 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    for (int i = 0; i < 4; i++) begin
      host.read_reg(dev_addr, offs[i], d);
      check("limit reset", d, rsts[i]);
      host.write_reg(dev_addr, offs[i], lims[i], ok);
      check("write ack", {7'h00, ok}, 8'h01);
      host.read_reg(dev_addr, offs[i], d);
      check("limit readback", d, lims[i]);
    end
    host.write_reg(dev_addr, 8'h6F, ~id_code, ok);
    host.read_reg(dev_addr, 8'h6F, d);
    check("part code", d, id_code);
    host.read_reg(dev_addr, 8'h70, d);
    check("unmapped read", d, btr_pkg::unmapped_read);
    // Wrong target address must be ignored entirely
    host.write_reg(dev_addr ^ 7'h01, 8'h62, 8'h00, ok);
    check("foreign ack", {7'h00, ok}, 8'h00);
    host.read_reg(dev_addr, 8'h62, d);
    check("foreign write", d, lims[0]);
    // Mid-run reset must bring the cold limit back to its reset code
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    host.read_reg(dev_addr, offs[0], d);
    check("cold after reset", d, rsts[0]);
    for (int i = 0; i < 4; i++) begin
      host.write_reg(dev_addr, offs[i], lims[i], ok);
      check("rewrite ack", {7'h00, ok}, 8'h01);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_in);
      sense <= svals[i];
      sense_valid <= 1'b1;
      @(posedge core_clk_in);
      sense_valid <= 1'b0;
      #1;
      check("zone", {5'h00, zone}, {5'h00, zexp[i]});
    end
    pulses = 0;
    @(posedge core_clk_in);
    button_n <= 1'b0;
    repeat (16) begin
      @(posedge core_clk_in);
      #1;
      pulses += int'(host_int === 1'b1);
    end
    check("button pulses", 8'(pulses), 8'h01);
    button_n <= 1'b1;
    wrap_up;
  end
endmodule // testbench
